// ### src/drg_pkg.sv
// package: register map, lock keys, processor constants for the run/lock guard
// assumes an apb slave with 32-bit data, word aligned registers
package drg_pkg;
	// ----------------------------------------
	// register indices (printed offsets are not all multiples of four)
	// ----------------------------------------
	localparam logic [15:0] RAM_FIRST_IDX   = 16'h4380;
	localparam logic [15:0] RAM_LAST_IDX    = 16'h43BE;
	localparam logic [15:0] LOCK_CTRL_IDX   = 16'hE7E3;
	localparam logic [15:0] LOCK_KEY_IDX    = 16'hE7FE;
	localparam logic [15:0] RUN_CTRL_IDX    = 16'hE228;
	localparam logic [15:0] MODE_CFG_IDX    = 16'hE229;
	localparam logic [15:0] STATUS_IDX      = 16'hE22A;
	localparam logic [15:0] SAMPLE_IDX      = 16'hE230;
	localparam logic [15:0] RMS_IDX         = 16'hE240;
	localparam logic [15:0] MAV_IDX         = 16'hE250;
	localparam logic [15:0] RMS_AVG_IDX     = 16'hE260;
	localparam logic [15:0] ENERGY_IDX      = 16'hE270;
	localparam int          RAM_WORDS       = 63;
	localparam int          CHANNELS        = 7;
	localparam int          PHASES          = 3;
	localparam int          NEUTRAL_CH      = 3;
	localparam int          ENERGY_REGS     = 5;
	// ----------------------------------------
	// field values
	// ----------------------------------------
	localparam logic [7:0]  LOCK_KEY_VAL    = 8'hAD;
	localparam logic [7:0]  LOCK_ON_VAL     = 8'h80;
	localparam logic [7:0]  LOCK_OFF_VAL    = 8'h00;
	localparam logic [15:0] RUN_STOP        = 16'h0000;
	localparam logic [15:0] RUN_START       = 16'h0001;
	localparam int          SUM_SEL_BIT     = 0;
	localparam int          FULL_PWR_BIT    = 1;
	localparam int          MON_PWR_BIT     = 2;
	localparam int          RAM_W           = 28;
	localparam int          RMS_W           = 24;
	localparam int          MAV_W           = 20;
	localparam int          SMP_W           = 24;
	localparam int          ACC_W           = 48;
	localparam int          LPF_SHIFT       = 6;
	localparam int          PIPE_DEPTH      = 2;
	// ----------------------------------------
	// timing: 8 kHz processing tick, 1.024 s averaging window
	// ----------------------------------------
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          TICK_HZ         = 8_000;
	localparam int          TICK_CYC        = CLK_HZ / TICK_HZ;
	localparam int          AVG_WINDOW_MS   = 1024;
	localparam int          AVG_SAMPLES     = AVG_WINDOW_MS * TICK_HZ / 1000;
	localparam int          AVG_SHIFT       = 13;
endpackage : drg_pkg

// ### src/drg_sqrt.sv
// iterative integer square root, one result bit per clock
// assumes start is pulsed only while busy is low
`timescale 1ns/1ns
module drg_sqrt
	import drg_pkg::*;
(
	input  wire logic              core_clk,  // device clock
	input  wire logic              rst_b,     // async reset, active low
	input  wire logic              start,     // begin a root
	input  wire logic [2*RMS_W-1:0] radicand, // value to root
	output logic                   busy,      // root in progress
	output logic                   done,      // one-cycle result strobe
	output logic [RMS_W-1:0]       root       // result
);
	logic [2*RMS_W-1:0] rem, next_rem;
	logic [RMS_W-1:0]   res, next_res;
	logic [4:0]         cnt, next_cnt;
	logic               next_busy, next_done;
	logic [RMS_W-1:0]   trial;

	// ----------------------------------------
	// bitwise restoring square root
	// ----------------------------------------
	always_comb begin
		next_rem  = rem;
		next_res  = res;
		next_cnt  = cnt;
		next_busy = busy;
		next_done = 1'b0;
		trial     = res | (RMS_W'(1) << cnt);
		if (start && !busy) begin
			next_rem  = radicand;
			next_res  = '0;
			next_cnt  = 5'(RMS_W - 1);
			next_busy = 1'b1;
		end else if (busy) begin
			if ({{RMS_W{1'b0}}, trial} * {{RMS_W{1'b0}}, trial} <= {{RMS_W{1'b0}}, rem})
				next_res = trial;
			if (cnt == 5'd0) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end else begin
				next_cnt = cnt - 5'd1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rem  <= '0;
			res  <= '0;
			cnt  <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			rem  <= next_rem;
			res  <= next_res;
			cnt  <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign root = res;
endmodule : drg_sqrt

// ### src/drg_guard.sv
// processor run control, keyed data ram write lock and rms/mav result paths
// assumes an apb master on core_clk; samples arrive on the same clock
`timescale 1ns/1ns
module drg_guard
	import drg_pkg::*;
(
	input  wire logic                  core_clk,  // 10 MHz device clock
	input  wire logic                  rst_b,     // async reset, active low
	input  wire logic                  psel,      // apb select
	input  wire logic                  penable,   // apb access phase
	input  wire logic                  pwrite,    // apb direction
	input  wire logic [17:0]           paddr,     // apb byte address
	input  wire logic [31:0]           pwdata,    // apb write data
	input  wire logic [3:0]            pstrb,     // apb byte strobes
	output logic                       pready,    // apb ready
	output logic [31:0]                prdata,    // apb read data
	output logic                       pslverr,   // apb error on unmapped address
	input  wire logic [CHANNELS*SMP_W-1:0] sampleIn, // channel samples, same clock
	input  wire logic [ENERGY_REGS*32-1:0] energyIn, // energy increments per tick
	output logic                       procRunning, // processor executing
	output logic                       ramLocked    // ram write lock engaged
);
	// every check below samples on the core clock and rests during reset
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// state and signals
	// ----------------------------------------
	logic [RAM_W-1:0]  ram [RAM_WORDS];
	logic [RAM_W-1:0]  pipeData [PIPE_DEPTH];
	logic [5:0]        pipeAddr [PIPE_DEPTH];
	logic [PIPE_DEPTH-1:0] pipeValid;
	logic [15:0]       runReg, next_runReg;
	logic              lockOn, next_lockOn;
	logic              keyArmed, next_keyArmed;
	logic [2:0]        modeCfg, next_modeCfg;
	logic              next_pready, next_pslverr;
	logic [31:0]       next_prdata;
	logic [31:0]       energy [ENERGY_REGS];
	logic [31:0]       next_energy [ENERGY_REGS];
	logic [11:0]       tickCnt;
	logic              tick;
	logic [ACC_W-1:0]  sqFilt [CHANNELS];
	logic [MAV_W+LPF_SHIFT-1:0] absFilt [PHASES];
	logic [RMS_W-1:0]  rmsRes [CHANNELS];
	logic [RMS_W-1:0]  rmsAvg [CHANNELS];
	logic [RMS_W+AVG_SHIFT-1:0] avgAcc [CHANNELS];
	logic [13:0]       avgCnt;
	logic [2:0]        rootCh;
	logic              rootBusy, rootDone, rootStart;
	logic [RMS_W-1:0]  rootVal;
	logic [15:0]       idx;
	logic              wrStb, rdStb, inRam;
	logic [5:0]        ramOfs;
	typedef enum logic [1:0] {DRG_IDLE, DRG_RUN} drg_state_t;
	drg_state_t        state, next_state;
	function automatic logic isRam(input logic [15:0] i);
		return (i >= RAM_FIRST_IDX) && (i <= RAM_LAST_IDX);
	endfunction : isRam
	function automatic logic [SMP_W-1:0] absVal(input logic [SMP_W-1:0] s);
		return s[SMP_W-1] ? SMP_W'(-s) : s;
	endfunction : absVal
	function automatic logic [SMP_W-1:0] chSample(input logic [CHANNELS*SMP_W-1:0] v,
		input int ch);
		return v[ch*SMP_W +: SMP_W];
	endfunction : chSample
	assign idx    = paddr[17:2];
	assign wrStb  = psel && penable && pwrite;
	assign rdStb  = psel && penable && !pwrite;
	assign inRam  = isRam(idx);
	assign ramOfs = 6'(idx - RAM_FIRST_IDX);

	// ----------------------------------------
	// control registers: run, lock, mode
	// ----------------------------------------
	always_comb begin
		next_runReg   = runReg;
		next_lockOn   = lockOn;
		next_keyArmed = keyArmed;
		next_modeCfg  = modeCfg;
		if (wrStb) begin
			next_keyArmed = 1'b0;
			if (idx == RUN_CTRL_IDX && pstrb[0])
				next_runReg = pwdata[15:0];
			if (idx == MODE_CFG_IDX && pstrb[0])
				next_modeCfg = pwdata[2:0];
			if (idx == LOCK_KEY_IDX && pwdata[7:0] == LOCK_KEY_VAL)
				next_keyArmed = 1'b1;
			if (idx == LOCK_CTRL_IDX && keyArmed) begin
				if (pwdata[7:0] == LOCK_ON_VAL)
					next_lockOn = 1'b1;
				else if (pwdata[7:0] == LOCK_OFF_VAL)
					next_lockOn = 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			runReg   <= RUN_STOP;
			lockOn   <= 1'b0;
			keyArmed <= 1'b0;
			modeCfg  <= '0;
		end else begin
			runReg   <= next_runReg;
			lockOn   <= next_lockOn;
			keyArmed <= next_keyArmed;
			modeCfg  <= next_modeCfg;
		end
	end

	// ----------------------------------------
	// processor state: idles until run reads one
	// ----------------------------------------
	always_comb begin
		case (state)
			DRG_IDLE: next_state = (runReg == RUN_START) ? DRG_RUN : DRG_IDLE;
			DRG_RUN:  next_state = (runReg == RUN_STOP) ? DRG_IDLE : DRG_RUN;
			default:  next_state = DRG_IDLE;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state       <= DRG_IDLE;
			procRunning <= 1'b0;
			ramLocked   <= 1'b0;
		end else begin
			state       <= next_state;
			procRunning <= (next_state == DRG_RUN);
			ramLocked   <= next_lockOn;
		end
	end

	// ----------------------------------------
	// data ram with two-deep write pipeline; the commit of a write waits
	// for two later accepted writes, so hosts must repeat the last one
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pipeValid <= '0;
			for (int i = 0; i < PIPE_DEPTH; i++) begin
				pipeData[i] <= '0;
				pipeAddr[i] <= '0;
			end
			for (int i = 0; i < RAM_WORDS; i++)
				ram[i] <= '0;
		end else if (wrStb && inRam && !lockOn) begin
			pipeData[0]  <= pwdata[RAM_W-1:0];
			pipeAddr[0]  <= ramOfs;
			pipeData[1]  <= pipeData[0];
			pipeAddr[1]  <= pipeAddr[0];
			pipeValid    <= {pipeValid[0], 1'b1};
			if (pipeValid[1])
				ram[pipeAddr[1]] <= pipeData[1];
		end
	end

	// ----------------------------------------
	// 8 kHz processing tick from the core clock
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt <= '0;
			tick    <= 1'b0;
		end else begin
			tick    <= (tickCnt == 12'(TICK_CYC - 1));
			tickCnt <= (tickCnt == 12'(TICK_CYC - 1)) ? '0 : tickCnt + 12'd1;
		end
	end

	// ----------------------------------------
	// rms path: square and low-pass each channel, then root in turn
	// ----------------------------------------
	logic [SMP_W-1:0] phaseSum;
	assign phaseSum = chSample(sampleIn, 0) + chSample(sampleIn, 1) + chSample(sampleIn, 2);
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gRms
			logic [SMP_W-1:0]   src;
			logic [SMP_W-1:0]   mag;
			logic [ACC_W-1:0]   sq;
			assign src = (g == NEUTRAL_CH && modeCfg[SUM_SEL_BIT])
				? phaseSum : chSample(sampleIn, g);
			assign mag = absVal(src);
			assign sq  = ACC_W'(mag) * ACC_W'(mag);
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b)
					sqFilt[g] <= '0;
				else if (tick && state == DRG_RUN && modeCfg[FULL_PWR_BIT])
					sqFilt[g] <= sqFilt[g] - (sqFilt[g] >> LPF_SHIFT)
						+ (sq >> LPF_SHIFT);
			end
		end
		for (g = 0; g < PHASES; g++) begin : gMav
			logic [SMP_W-1:0] mag;
			assign mag = absVal(chSample(sampleIn, g));
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b)
					absFilt[g] <= '0;
				else if (tick && state == DRG_RUN
					&& (modeCfg[FULL_PWR_BIT] || modeCfg[MON_PWR_BIT]))
					absFilt[g] <= absFilt[g] - (absFilt[g] >> LPF_SHIFT)
						+ (MAV_W+LPF_SHIFT)'(mag >> (SMP_W - MAV_W));
			end
		end
	endgenerate
	assign rootStart = tick && !rootBusy && state == DRG_RUN && modeCfg[FULL_PWR_BIT];
	drg_sqrt uRoot (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.start    (rootStart),
		.radicand (sqFilt[rootCh]),
		.busy     (rootBusy),
		.done     (rootDone),
		.root     (rootVal)
	);
	// rotate through the channels, one root per tick; also the 1.024 s average
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rootCh <= '0;
			avgCnt <= '0;
			for (int i = 0; i < CHANNELS; i++) begin
				rmsRes[i] <= '0;
				rmsAvg[i] <= '0;
				avgAcc[i] <= '0;
			end
		end else begin
			if (rootDone) begin
				rmsRes[rootCh] <= rootVal;
				rootCh <= (rootCh == 3'(CHANNELS - 1)) ? '0 : rootCh + 3'd1;
			end
			if (tick && state == DRG_RUN && modeCfg[FULL_PWR_BIT]) begin
				if (avgCnt == 14'(AVG_SAMPLES - 1)) begin
					avgCnt <= '0;
					for (int i = 0; i < CHANNELS; i++) begin
						rmsAvg[i] <= RMS_W'((avgAcc[i] + rmsRes[i]) >> AVG_SHIFT);
						avgAcc[i] <= '0;
					end
				end else begin
					avgCnt <= avgCnt + 14'd1;
					for (int i = 0; i < CHANNELS; i++)
						avgAcc[i] <= avgAcc[i] + (RMS_W+AVG_SHIFT)'(rmsRes[i]);
				end
			end
		end
	end

	// ----------------------------------------
	// energy accumulators; a read clears, and a same-cycle tick adds its increment to the cleared value
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < ENERGY_REGS; i++) begin
			next_energy[i] = energy[i];
			if (rdStb && idx == ENERGY_IDX + 16'(i))
				next_energy[i] = '0;
			if (tick && state == DRG_RUN)
				next_energy[i] = next_energy[i] + energyIn[i*32 +: 32];
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < ENERGY_REGS; i++)
				energy[i] <= '0;
		end else begin
			for (int i = 0; i < ENERGY_REGS; i++)
				energy[i] <= next_energy[i];
		end
	end

	// ----------------------------------------
	// apb answer: ready in the first access cycle, error on unmapped index
	// ----------------------------------------
	always_comb begin
		next_pready  = psel && !penable;
		next_pslverr = 1'b0;
		next_prdata  = '0;
		if (psel && !penable) begin
			if (inRam)
				next_prdata = 32'(ram[ramOfs]);
			else if (idx == RUN_CTRL_IDX)
				next_prdata = 32'(runReg);
			else if (idx == MODE_CFG_IDX)
				next_prdata = 32'(modeCfg);
			else if (idx == STATUS_IDX)
				next_prdata = {30'h0000_0000, lockOn, state == DRG_RUN};
			else if (idx >= SAMPLE_IDX && idx < SAMPLE_IDX + 16'(CHANNELS))
				next_prdata = 32'(rmsRes[3'(idx - SAMPLE_IDX)]);
			else if (idx >= RMS_IDX && idx < RMS_IDX + 16'(CHANNELS))
				next_prdata = 32'(rmsRes[3'(idx - RMS_IDX)]);
			else if (idx >= MAV_IDX && idx < MAV_IDX + 16'(PHASES))
				next_prdata = 32'(absFilt[2'(idx - MAV_IDX)] >> LPF_SHIFT);
			else if (idx >= RMS_AVG_IDX && idx < RMS_AVG_IDX + 16'(CHANNELS))
				next_prdata = 32'(rmsAvg[3'(idx - RMS_AVG_IDX)]);
			else if (idx >= ENERGY_IDX && idx < ENERGY_IDX + 16'(ENERGY_REGS))
				next_prdata = energy[3'(idx - ENERGY_IDX)];
			else if (idx != LOCK_CTRL_IDX && idx != LOCK_KEY_IDX)
				next_pslverr = 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence keySeq;
		wrStb && idx == LOCK_KEY_IDX && pwdata[7:0] == LOCK_KEY_VAL;
	endsequence
	// control write after the key, with only the idle and setup cycles between
	sequence ctrlSeq(logic [7:0] val);
		(!wrStb) [*2] ##1 (wrStb && idx == LOCK_CTRL_IDX && pwdata[7:0] == val);
	endsequence
	chk_run_start: assert property (runReg == RUN_START && state == DRG_IDLE
		|=> procRunning) else $error("processor did not start");
	chk_run_stop: assert property (runReg == RUN_STOP
		|=> !procRunning) else $error("processor did not stop");
	chk_lock_on: assert property (keySeq ##1 ctrlSeq(LOCK_ON_VAL)
		|=> lockOn) else $error("lock not engaged");
	chk_lock_off: assert property (keySeq ##1 ctrlSeq(LOCK_OFF_VAL)
		|=> !lockOn) else $error("lock not released");
	chk_locked_ram: assert property (lockOn && wrStb && inRam
		|=> $stable(pipeValid) && $stable(pipeData[0])) else $error("locked ram took a write");
	chk_key_cancel: assert property (wrStb && idx != LOCK_KEY_IDX
		|=> !keyArmed) else $error("key survived another write");
	chk_energy_clear: assert property (rdStb && idx == ENERGY_IDX && !tick
		|=> energy[0] == '0) else $error("energy not cleared on read");
	chk_rms_mode: assert property (!modeCfg[FULL_PWR_BIT]
		|=> $stable(sqFilt[0])) else $error("rms path ran outside full power");
	chk_apb_ready: assert property (psel && !penable
		|=> pready ##1 !pready) else $error("apb ready not one cycle");
endmodule : drg_guard

// ### tb/drg_host.sv
// host controller model: an apb master issuing one transfer at a time
// assumes the slave answers with pready on core_clk
`timescale 1ns/1ns
module drg_host (
	input  wire logic        core_clk, // device clock
	output logic             psel,     // apb select
	output logic             penable,  // apb access phase
	output logic             pwrite,   // apb direction
	output logic [17:0]      paddr,    // apb byte address
	output logic [31:0]      pwdata,   // apb write data
	output logic [3:0]       pstrb,    // apb byte strobes
	input  wire logic        pready,   // apb ready
	input  wire logic [31:0] prdata,   // apb read data
	input  wire logic        pslverr   // apb error
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
	end
	// ----------------------------------------
	// one transfer, held until pready is seen at a rising edge
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data lines must not keep looking valid
		pwdata <= ~d;
	endtask : xfer
endmodule : drg_host

// ### tb/tb_dsp_run_and_ram_write_guard.sv
// self-checking bench for the run control and ram write lock
// assumes drg_guard answers every transfer; a reference model tracks the ram
`timescale 1ns/1ns
module tb_dsp_run_and_ram_write_guard
	import drg_pkg::*;
;
	logic                     core_clk = 1'b0; // 10 MHz clock
	logic                     rst_b    = 1'b0; // reset, active low
	logic                     psel, penable, pwrite, pready, pslverr;
	logic [17:0]              paddr;
	logic [31:0]              pwdata, prdata, v;
	logic [3:0]               pstrb;
	logic [CHANNELS*SMP_W-1:0] sampleIn = '0;
	logic [ENERGY_REGS*32-1:0] energyIn = '0;
	logic                     procRunning, ramLocked, locked, keyArm;
	logic [27:0]              ram [RAM_WORDS];
	logic [27:0]              pDat [$];
	int                       pIdx [$];
	int                       n_errors = 0;
	int                       tests_run = 0;
	int                       cyc = 0;
	always #50 core_clk = ~core_clk;
	drg_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));
	drg_guard dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .sampleIn(sampleIn), .energyIn(energyIn),
		.procRunning(procRunning), .ramLocked(ramLocked));
	// random samples and energy steps; a hang is cut short
	always @(posedge core_clk) begin
		for (int c = 0; c < CHANNELS; c++) sampleIn[c*SMP_W +: SMP_W] <= SMP_W'($urandom());
		for (int e = 0; e < ENERGY_REGS; e++) energyIn[e*32 +: 32] <= 32'($urandom_range(99, 1));
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// compare, bus and model tasks
	// ----------------------------------------
	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkWord
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	// a write, mirrored into the model; locked ram writes never enter the pipe
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		host.xfer(1'b1, idx, d, q, e);
		if (idx >= RAM_FIRST_IDX && idx <= RAM_LAST_IDX && !locked) begin
			pIdx.push_back(int'(idx - RAM_FIRST_IDX));
			pDat.push_back(d[27:0]);
			if (pIdx.size() > PIPE_DEPTH) ram[pIdx.pop_front()] = pDat.pop_front();
		end
		if (idx == LOCK_CTRL_IDX && keyArm) locked = (d[7:0] == LOCK_ON_VAL) ? 1'b1 :
			(d[7:0] == LOCK_OFF_VAL) ? 1'b0 : locked;
		keyArm = (idx == LOCK_KEY_IDX) && (d[7:0] == LOCK_KEY_VAL);
	endtask : wr
	task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp, input logic ee);
		logic [31:0] q;
		logic        e;
		host.xfer(1'b0, idx, 32'h0000_0000, q, e);
		chkWord(q, exp);
		chkWord({31'b0, e}, {31'b0, ee});
	endtask : rdChk
	task automatic verifyRam();
		for (int i = 0; i < RAM_WORDS; i++) rdChk(RAM_FIRST_IDX + 16'(i), {4'h0, ram[i]}, 1'b0);
	endtask : verifyRam
	task automatic lockSet(input logic [7:0] c);
		wr(LOCK_KEY_IDX, {24'h0, LOCK_KEY_VAL});
		wr(LOCK_CTRL_IDX, {24'h0, c});
	endtask : lockSet
	task automatic chkFlags(input logic run, input logic lk);
		repeat (2) @(negedge core_clk);
		chkWord({31'b0, procRunning}, {31'b0, run});
		chkWord({31'b0, ramLocked}, {31'b0, lk});
	endtask : chkFlags
	task automatic doReset();
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		foreach (ram[i]) ram[i] = '0;
		pIdx.delete();
		pDat.delete();
		locked = 1'b0;
		keyArm = 1'b0;
		chkFlags(1'b0, 1'b0);
		rdChk(RUN_CTRL_IDX, {16'h0, RUN_STOP}, 1'b0);
		verifyRam();
	endtask : doReset
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h76b7d6af));
		doReset();
		for (int i = 0; i < 8; i++) wr(RAM_FIRST_IDX + 16'(i), $urandom());
		verifyRam();
		v = $urandom();
		repeat (3) wr(RAM_LAST_IDX, v);
		verifyRam();
		lockSet(LOCK_ON_VAL);
		chkFlags(1'b0, 1'b1);
		repeat (3) wr(RAM_FIRST_IDX + 16'h0002, $urandom());
		verifyRam();
		wr(LOCK_KEY_IDX, {24'h0, LOCK_KEY_VAL});
		wr(RUN_CTRL_IDX, {16'h0, RUN_START});
		wr(LOCK_CTRL_IDX, {24'h0, LOCK_OFF_VAL});
		chkFlags(1'b1, 1'b1);
		wr(LOCK_KEY_IDX, 32'h0000_005A);
		wr(LOCK_CTRL_IDX, {24'h0, LOCK_OFF_VAL});
		chkFlags(1'b1, 1'b1);
		lockSet(LOCK_OFF_VAL);
		chkFlags(1'b1, 1'b0);
		v = $urandom();
		repeat (3) wr(RAM_FIRST_IDX + 16'h000A, v);
		lockSet(LOCK_ON_VAL);
		chkFlags(1'b1, 1'b1);
		verifyRam();
		wr(MODE_CFG_IDX, 32'(1 << MON_PWR_BIT));
		repeat (3 * TICK_CYC) @(posedge core_clk);
		rdChk(MODE_CFG_IDX, 32'(1 << MON_PWR_BIT), 1'b0);
		rdChk(RMS_IDX + 16'(NEUTRAL_CH), 32'h0000_0000, 1'b0);
		wr(RUN_CTRL_IDX, {16'h0, RUN_STOP});
		chkFlags(1'b0, 1'b1);
		for (int e = 0; e < ENERGY_REGS; e++) host.xfer(1'b0, ENERGY_IDX + 16'(e), 32'h0, v, keyArm);
		for (int e = 0; e < ENERGY_REGS; e++) rdChk(ENERGY_IDX + 16'(e), 32'h0, 1'b0);
		keyArm = 1'b0;
		// pulse enables live outside this block, so setup ends with the energy reads
		wr(RUN_CTRL_IDX, {16'h0, RUN_START});
		chkFlags(1'b1, 1'b1);
		rdChk(RUN_CTRL_IDX, {16'h0, RUN_START}, 1'b0);
		rdChk(16'h0001, 32'h0, 1'b1);
		doReset();
		wrap_up();
	end
endmodule : tb_dsp_run_and_ram_write_guard
